// ===== arwc_adc_result_mux_window_cmp.v
// Converter back end: input select shadowing, result packing, window compare
// Functional notes
// - Single differential result sits in 11..0 sign-extended, or 15..4 when left-adjusted.
// - 2/4/8 sums are 13/14/15 bits, sign-extended or padded 3/2/1 zeros.
// - 32/64/128 sums drop low bits to fit 16; left adjust ignored.
// - Single-ended routes only positive select; differential routes both selects.
// - Shadow selects track software fields continuously while idle.
// - Shadow selects freeze from conversion start; writes meanwhile do not reach core.
// - Tracking resumes in last converter clock cycle before completion.
// - Start command begins conversion at next rising clock edge.
// - Window flag set and interrupt requested when result meets condition.
// - Four conditions: below, above, inside, outside thresholds.
// - Thresholds from two registers; condition from window mode field.
// - Comparator works only with a valid non-zero mode code.
// - Window interrupt enable bit gates the flag onto the request.
// - Accumulations compare once, after the last sample.
// - Compare uses the final stored result word, not individual samples.
// - Single-ended stored unsigned zero-extended; differential two's complement sign-extended.
// - Right-adjusted by default; left adjust puts top eight bits in high byte.
// - Accumulation count from 3-bit field; truncate beyond 16 samples.
`timescale 1ns/10ps
`include "arwc_consts.vh"

module arwc_adc_result_mux_window_cmp (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire start_conversion_cmd,
  input wire differential_mode,
  input wire left_adjust_result,
  input wire [2:0] accumulation_count_field,
  input wire [6:0] positive_input_select,
  input wire [6:0] negative_input_select,
  input wire [2:0] window_mode_field,
  input wire [15:0] window_low_threshold,
  input wire [15:0] window_high_threshold,
  input wire window_int_enable,
  input wire window_flag_clear,
  input wire core_last_cycle,
  input wire core_sample_valid,
  input wire [11:0] core_sample,
  output reg [6:0] core_pos_select,
  output reg [6:0] core_neg_select,
  output wire core_start,
  output wire conversion_busy,
  output reg [15:0] result_word,
  output reg result_ready,
  output reg window_compare_flag,
  output wire window_irq
);

  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [6:0] pos_shadow_reg;
  reg [6:0] neg_shadow_reg;
  reg [22:0] acc_reg;
  reg [7:0] count_reg;
  reg [15:0] packed_word;
  reg cmp_hit;
  reg [22:0] acc_sum;
  reg [7:0] target;
  reg done;
  reg [6:0] pos_shadow_next;
  reg [6:0] neg_shadow_next;
  reg [6:0] core_pos_next;
  reg [6:0] core_neg_next;
  reg [22:0] acc_next;
  reg [7:0] count_next;
  reg [15:0] result_next;
  reg flag_next;

  wire [22:0] sample_ext;
  wire is_idle;
  wire lock_open;
  wire below_low;
  wire above_low;
  wire below_high;
  wire above_high;

  assign is_idle = state_reg[0];
  assign conversion_busy = state_reg[1];
  // Start sampled on the clock edge; conversion runs from that edge
  // Gated by the enable so a frozen block never launches the core
  assign core_start = clk_en & is_idle & start_conversion_cmd;
  // Open while idle and in the core's final cycle
  assign lock_open = is_idle | core_last_cycle;

  assign sample_ext = differential_mode ? {{11{core_sample[11]}}, core_sample} :
    {11'h000, core_sample};

  always @* begin
    case (accumulation_count_field)
      `ARWC_ACC_1: target = 8'h01;
      `ARWC_ACC_2: target = 8'h02;
      `ARWC_ACC_4: target = 8'h04;
      `ARWC_ACC_8: target = 8'h08;
      `ARWC_ACC_16: target = 8'h10;
      `ARWC_ACC_32: target = 8'h20;
      `ARWC_ACC_64: target = 8'h40;
      default: target = 8'h80;
    endcase
  end

  always @* begin
    acc_sum = (count_reg == 8'h00) ? sample_ext : acc_reg + sample_ext;
    done = core_sample_valid & conversion_busy & ((count_reg + 8'h01) == target);
  end

  // Pack the final sum; differential sign extends, single-ended zero-extends
  always @* begin
    packed_word = `ARWC_RES_RESET;
    case (accumulation_count_field)
      `ARWC_ACC_1: packed_word = left_adjust_result ? {acc_sum[11:0], 4'h0} :
        acc_sum[15:0];
      `ARWC_ACC_2: packed_word = left_adjust_result ? {acc_sum[12:0], 3'h0} :
        acc_sum[15:0];
      `ARWC_ACC_4: packed_word = left_adjust_result ? {acc_sum[13:0], 2'h0} :
        acc_sum[15:0];
      `ARWC_ACC_8: packed_word = left_adjust_result ? {acc_sum[14:0], 1'b0} :
        acc_sum[15:0];
      `ARWC_ACC_16: packed_word = acc_sum[15:0];
      `ARWC_ACC_32: packed_word = acc_sum[16:1];
      `ARWC_ACC_64: packed_word = acc_sum[17:2];
      `ARWC_ACC_128: packed_word = acc_sum[18:3];
      default: packed_word = acc_sum[15:0];
    endcase
  end

  // Compare runs on the packed word, so left adjust keeps thresholds sample-count free
  arwc_thr_cmp #(
    .WIDTH(`ARWC_RES_W)
  ) i_low_cmp (
    .value(packed_word),
    .threshold(window_low_threshold),
    .signed_mode(differential_mode),
    .less_than(below_low),
    .greater_than(above_low)
  );

  arwc_thr_cmp #(
    .WIDTH(`ARWC_RES_W)
  ) i_high_cmp (
    .value(packed_word),
    .threshold(window_high_threshold),
    .signed_mode(differential_mode),
    .less_than(below_high),
    .greater_than(above_high)
  );

  // Codes 5..7 fall to the default and never hit
  always @* begin
    cmp_hit = 1'b0;
    case (window_mode_field)
      `ARWC_WIN_BELOW: cmp_hit = below_low;
      `ARWC_WIN_ABOVE: cmp_hit = above_high;
      `ARWC_WIN_INSIDE: cmp_hit = above_low & below_high;
      `ARWC_WIN_OUTSIDE: cmp_hit = below_low | above_high;
      default: cmp_hit = 1'b0;
    endcase
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_conversion_cmd) state_next = ST_CONV;
      ST_CONV: if (done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  assign window_irq = window_compare_flag & window_int_enable;

  // Shadows follow software while the lock is open, hold otherwise
  always @* begin
    pos_shadow_next = pos_shadow_reg;
    neg_shadow_next = neg_shadow_reg;
    if (lock_open) begin
      pos_shadow_next = positive_input_select;
      neg_shadow_next = negative_input_select;
    end
  end

  always @* begin
    core_pos_next = lock_open ? positive_input_select : pos_shadow_reg;
    // Negative select held at zero when single-ended
    core_neg_next = `ARWC_SEL_RESET;
    if (differential_mode)
      core_neg_next = lock_open ? negative_input_select : neg_shadow_reg;
  end

  always @* begin
    acc_next = acc_reg;
    count_next = count_reg;
    if (core_start) begin
      count_next = 8'h00;
    end else if (conversion_busy && core_sample_valid) begin
      acc_next = acc_sum;
      count_next = done ? 8'h00 : count_reg + 8'h01;
    end
  end

  always @* begin
    result_next = result_word;
    if (done)
      result_next = packed_word;
  end

  // Set wins over a clear in the same cycle
  always @* begin
    flag_next = window_compare_flag;
    if (done && cmp_hit)
      flag_next = 1'b1;
    else if (window_flag_clear)
      flag_next = 1'b0;
  end

  // Every register below holds while the clock enable is low
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pos_shadow_reg <= `ARWC_SEL_RESET;
      neg_shadow_reg <= `ARWC_SEL_RESET;
    end else if (clk_en) begin
      pos_shadow_reg <= pos_shadow_next;
      neg_shadow_reg <= neg_shadow_next;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_pos_select <= `ARWC_SEL_RESET;
      core_neg_select <= `ARWC_SEL_RESET;
    end else if (clk_en) begin
      core_pos_select <= core_pos_next;
      core_neg_select <= core_neg_next;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 23'h000000;
      count_reg <= 8'h00;
    end else if (clk_en) begin
      acc_reg <= acc_next;
      count_reg <= count_next;
    end
  end

  // Ready is a one-cycle strobe on the edge that stores the word
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_word <= `ARWC_RES_RESET;
      result_ready <= 1'b0;
    end else if (clk_en) begin
      result_word <= result_next;
      result_ready <= done;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      window_compare_flag <= 1'b0;
    end else if (clk_en) begin
      window_compare_flag <= flag_next;
    end
  end

endmodule

// Compare of a result word against one threshold, signed or unsigned
module arwc_thr_cmp #(
  parameter WIDTH = 16
) (
  input wire [WIDTH-1:0] value,
  input wire [WIDTH-1:0] threshold,
  input wire signed_mode,
  output wire less_than,
  output wire greater_than
);
  wire [WIDTH:0] value_ext;
  wire [WIDTH:0] thr_ext;
  // One extra bit lets a single signed compare serve both formats
  assign value_ext = {signed_mode & value[WIDTH-1], value};
  assign thr_ext = {signed_mode & threshold[WIDTH-1], threshold};
  assign less_than = $signed(value_ext) < $signed(thr_ext);
  assign greater_than = $signed(value_ext) > $signed(thr_ext);
endmodule

// ===== arwc_consts.vh
// Constants for the converter result packing and window compare block
`ifndef ARWC_CONSTS_VH
`define ARWC_CONSTS_VH
`define ARWC_RES_W 16
`define ARWC_SEL_W 7
`define ARWC_SEL_RESET 7'h00
`define ARWC_RES_RESET 16'h0000
`define ARWC_ACC_1 3'h0
`define ARWC_ACC_2 3'h1
`define ARWC_ACC_4 3'h2
`define ARWC_ACC_8 3'h3
`define ARWC_ACC_16 3'h4
`define ARWC_ACC_32 3'h5
`define ARWC_ACC_64 3'h6
`define ARWC_ACC_128 3'h7
`define ARWC_WIN_OFF 3'h0
`define ARWC_WIN_BELOW 3'h1
`define ARWC_WIN_ABOVE 3'h2
`define ARWC_WIN_INSIDE 3'h3
`define ARWC_WIN_OUTSIDE 3'h4
`endif

// ===== arwc_chk_sva.sv
// Port-level checker for the converter back end
`timescale 1ns/10ps
module arwc_chk (
  input wire mclk, reset_n, clk_en, start_conversion_cmd, differential_mode,
  input wire window_flag_clear, window_int_enable, core_last_cycle, core_start,
  input wire conversion_busy, result_ready, window_compare_flag, window_irq,
  input wire [2:0] window_mode_field,
  input wire [6:0] positive_input_select, negative_input_select,
  input wire [6:0] core_pos_select, core_neg_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_START: assert property (clk_en && start_conversion_cmd && !conversion_busy |-> core_start)
    else $error("start not taken");
  AST_BUSY: assert property (clk_en && core_start |=> conversion_busy)
    else $error("no busy after start");
  AST_REFUSE: assert property (conversion_busy |-> !core_start)
    else $error("start while busy");
  AST_TRACK: assert property (clk_en && (!conversion_busy || core_last_cycle) |=> core_pos_select == $past(positive_input_select))
    else $error("select not tracking");
  AST_FREEZE: assert property (clk_en && conversion_busy && !core_last_cycle |=> $stable(core_pos_select) && $stable(core_neg_select))
    else $error("select moved while locked");
  AST_NEG: assert property (clk_en && !conversion_busy |=> core_neg_select == ($past(differential_mode) ? $past(negative_input_select) : 7'h00))
    else $error("negative select wrong");
  AST_IRQ: assert property (window_irq == (window_compare_flag && window_int_enable))
    else $error("irq not flag and enable");
  AST_SET: assert property ($rose(window_compare_flag) |-> result_ready && $past(window_mode_field) inside {[3'h1:3'h4]})
    else $error("flag set without result");
  AST_CLR: assert property (clk_en && window_flag_clear ##1 !result_ready |-> !window_compare_flag)
    else $error("flag not cleared");
  AST_PULSE: assert property (clk_en && result_ready |=> !result_ready)
    else $error("ready longer than a cycle");
endmodule
bind arwc_adc_result_mux_window_cmp arwc_chk i_chk (.*);

// ===== arwc_core_model.sv
// Behavioural converter core: a burst of equal samples after each start
`timescale 1ns/10ps
module arwc_core_model (
  input wire mclk, reset_n, core_start,
  input wire [7:0] n_samples,
  input wire [3:0] gap,
  input wire [11:0] value,
  output reg core_sample_valid, core_last_cycle,
  output reg [11:0] core_sample
);
  integer left = 0;
  integer hold = 0;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left = 0;
      core_sample_valid <= 1'b0;
      core_last_cycle <= 1'b0;
      core_sample <= 12'h5A5;
    end else begin
      core_sample_valid <= 1'b0;
      core_last_cycle <= 1'b0;
      // Idle data toggles so a stale sample never looks valid
      core_sample <= ~core_sample;
      if (core_start) begin
        left = n_samples;
        // Start gap stands in for the initialisation delay software sets
        hold = gap;
      end else if (left > 0 && hold > 0) begin
        hold = hold - 1;
      end else if (left > 0) begin
        core_sample_valid <= 1'b1;
        core_last_cycle <= (left == 1);
        core_sample <= value;
        left = left - 1;
        hold = gap;
      end
    end
  end
endmodule

// ===== arwc_adc_result_mux_window_cmp_tb.sv
// Self-checking bench for the converter back end
`timescale 1ns/10ps
module arwc_adc_result_mux_window_cmp_tb;
  reg mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, start_conversion_cmd = 1'b0;
  reg differential_mode = 1'b0, left_adjust_result = 1'b0, window_int_enable = 1'b0;
  reg window_flag_clear = 1'b0;
  reg [2:0] accumulation_count_field = 3'h0, window_mode_field = 3'h0;
  reg [6:0] positive_input_select = 7'h00, negative_input_select = 7'h00;
  reg [15:0] window_low_threshold = 16'h0000, window_high_threshold = 16'h0000;
  reg [7:0] n_samples = 8'h01;
  reg [3:0] gap = 4'h0;
  reg [11:0] value = 12'h000;
  wire core_last_cycle, core_sample_valid, core_start, conversion_busy, result_ready;
  wire window_compare_flag, window_irq;
  wire [11:0] core_sample;
  wire [6:0] core_pos_select, core_neg_select;
  wire [15:0] result_word;
  integer fail_count = 0;
  integer checks_done = 0;
  arwc_adc_result_mux_window_cmp i_dut (.*);
  arwc_core_model i_core (.*);
  always #4 mclk = ~mclk;
  task check(input string what, input logic [15:0] exp, got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function integer ext(input d, input [15:0] w);
    ext = d ? {{16{w[15]}}, w} : {16'h0000, w};
  endfunction
  function [15:0] pack(input d, l, input [2:0] a, input [11:0] v);
    integer s;
    s = ext(d, {{4{d & v[11]}}, v}) <<< a;
    // Long sums drop low bits and ignore left adjust
    pack = a > 3'h4 ? s >>> (a - 3'h4) : s <<< (l ? 3'h4 - a : 3'h0);
  endfunction
  function hit(input [2:0] m, input d, input [15:0] w);
    integer x, lo, hi;
    x = ext(d, w);
    lo = ext(d, window_low_threshold);
    hi = ext(d, window_high_threshold);
    hit = m == 3'h1 ? x < lo : m == 3'h2 ? x > hi : m == 3'h3 ? x > lo && x < hi :
      m == 3'h4 ? x < lo || x > hi : 1'b0;
  endfunction
  task conv(input d, l, input [2:0] a, input [11:0] v, input [3:0] g);
    integer i;
    differential_mode = d;
    left_adjust_result = l;
    accumulation_count_field = a;
    value = v;
    gap = g;
    n_samples = 8'h01 << a;
    start_conversion_cmd = 1'b1;
    @(posedge mclk) #1;
    start_conversion_cmd = 1'b0;
    for (i = 0; i < 3000 && result_ready !== 1'b1; i = i + 1) @(posedge mclk) #1;
  endtask
  task t_pack;
    integer d, l, a;
    for (d = 0; d < 2; d = d + 1) for (l = 0; l < 2; l = l + 1) for (a = 0; a < 8; a = a + 1) begin
      conv(d, l, a, 12'h9A7, 4'h0);
      check("result_word", pack(d, l, a, 12'h9A7), result_word);
    end
    check("flag off", 16'h0000, 16'(window_compare_flag));
    $display("t_pack done");
  endtask
  task t_window;
    integer d, m, k;
    reg [11:0] v;
    reg h;
    window_low_threshold = 16'hFF9C;
    window_high_threshold = 16'h0064;
    for (d = 0; d < 2; d = d + 1) for (m = 0; m < 8; m = m + 1) for (k = 0; k < 3; k = k + 1) begin
      v = k == 0 ? 12'hF38 : k == 1 ? 12'h000 : 12'h0C8;
      window_mode_field = m;
      window_int_enable = k[0];
      window_flag_clear = 1'b1;
      @(posedge mclk) #1;
      window_flag_clear = 1'b0;
      conv(d, 1'b1, 3'h1, v, 4'h0);
      h = hit(m, d, pack(d, 1'b1, 3'h1, v));
      check("flag", 16'(h), 16'(window_compare_flag));
      check("irq", 16'(h & k[0]), 16'(window_irq));
    end
    $display("t_window done");
  endtask
  task t_mux;
    positive_input_select = 7'h11;
    negative_input_select = 7'h22;
    conv(1'b1, 1'b0, 3'h0, 12'h001, 4'h0);
    check("pos idle", 16'h0011, 16'(core_pos_select));
    check("neg diff", 16'h0022, 16'(core_neg_select));
    fork
      conv(1'b1, 1'b0, 3'h2, 12'h001, 4'h3);
      begin
        @(posedge mclk) #1;
        positive_input_select = 7'h33;
        repeat (4) @(posedge mclk) #1;
        check("pos locked", 16'h0011, 16'(core_pos_select));
      end
    join
    check("pos resumed", 16'h0033, 16'(core_pos_select));
    conv(1'b0, 1'b0, 3'h0, 12'h001, 4'h0);
    check("neg single", 16'h0000, 16'(core_neg_select));
    $display("t_mux done");
  endtask
  task t_freeze;
    clk_en = 1'b0;
    start_conversion_cmd = 1'b1;
    repeat (3) @(posedge mclk) #1;
    check("busy frozen", 16'h0000, 16'(conversion_busy));
    check("start frozen", 16'h0000, 16'(core_start));
    start_conversion_cmd = 1'b0;
    clk_en = 1'b1;
    @(posedge mclk) #1;
    $display("t_freeze done");
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_pack;
    t_window;
    t_mux;
    t_freeze;
    end_sim;
  end
endmodule
